// ### fll_pll_clock_mode_control_bench.sv
// Self-checking bench for the clock mode control
`timescale 1ns/1ns
module fll_pll_clock_mode_control_bench;
	import fpc_pkg::*;
	logic ref_clk_i = 1'b0;
	logic srst_i = 1'b1;
	fpc_axi_req_s req = '0;
	fpc_axi_rsp_s rsp;
	logic pwr = 1'b0, drift = 1'b0, fail = 1'b0;
	logic osc_rdy, lost_lock, lost_clk, irq, rreq, fll_en, pll_en, bdm, iref, fine_period_adjust;
	logic [1:0] src;
	logic [2:0] reference_divider;
	logic [5:0] vco;
	logic [8:0] mode;
	int errors = 0, checks = 0, cyc = 0;
	logic [33:0] notes[$];
	logic [15:0] lfsr = 16'hb6be;

	always #2 ref_clk_i = ~ref_clk_i;

	fpc_clock_ctrl DUT (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .axi_req_i(req), .axi_rsp_o(rsp),
		.osc_ready_i(osc_rdy), .lock_lost_i(lost_lock), .ext_clk_lost_i(lost_clk), .stop_i(1'b0),
		.irq_o(irq), .reset_req_o(rreq), .fll_enable_o(fll_en), .pll_enable_o(pll_en), .out_src_o(src),
		.bdm_from_fll_o(bdm), .int_ref_o(iref), .ref_div_o(reference_divider), .fine_period_adjust_o(fine_period_adjust),
		.vco_factor_o(vco), .mode_o(mode));
	fpc_osc_model osc (.ref_clk_i(ref_clk_i), .power_i(pwr), .drift_i(drift), .fail_i(fail),
		.osc_ready_o(osc_rdy), .lock_lost_o(lost_lock), .ext_clk_lost_o(lost_clk));

	function automatic logic [15:0] next_rnd(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task give_verdict;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// --------------------
	// Bus master tasks
	// --------------------
	// Random upper data bits land in unused lanes and must change nothing
	task wr(input logic [7:0] a, input logic [8:0] d, input logic [1:0] r);
		notes.push_back({r, 32'h0});
		@(posedge ref_clk_i);
		lfsr = next_rnd(lfsr);
		req.awaddr <= a;
		req.wdata <= {lfsr, 7'h0, d};
		req.wstrb <= 4'hf;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do
		begin
			@(posedge ref_clk_i);
			if (rsp.awready)
				req.awvalid <= 1'b0;
			if (rsp.wready)
				req.wvalid <= 1'b0;
		end while (!rsp.bvalid);
		req.bready <= 1'b0;
		#1;
	endtask

	task rd(input logic [7:0] a, input logic [8:0] v, input logic [1:0] r);
		notes.push_back({r, 23'h0, v});
		@(posedge ref_clk_i);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do
		begin
			@(posedge ref_clk_i);
			if (rsp.arready)
				req.arvalid <= 1'b0;
		end while (!rsp.rvalid);
		req.rready <= 1'b0;
		#1;
	endtask

	task wait_mode(input logic [8:0] m);
		for (int i = 0; i < 60 && mode !== m; i++)
			@(posedge ref_clk_i);
		#1;
		check(34'(mode), 34'(m));
	endtask

	always @(posedge ref_clk_i)
		if ((rsp.rvalid && req.rready) || (rsp.bvalid && req.bready))
			check(rsp.rvalid ? {rsp.rresp, rsp.rdata} : {rsp.bresp, 32'h0}, notes.pop_front());

	always @(posedge ref_clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			errors++;
			give_verdict();
		end
	end

	// --------------------
	// Main sequence
	// --------------------
	initial
	begin
		repeat (12) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		repeat (6) @(posedge ref_clk_i);
		rd(OFF_CTL3, 9'(RST_CTL3), RESP_OK);
		rd(OFF_SRC, RST_SRC, RESP_OK);
		rd(OFF_MODE, M_FEI, RESP_OK);
		check(34'({src, bdm, pll_en, fll_en}), 34'h5);
		rd(8'h10, 9'h0, RESP_ERR);
		wr(8'h10, 9'h0, RESP_ERR);
		for (int c = 0; c < 16; c++)
		begin
			wr(OFF_CTL3, 9'(c), RESP_OK);
			check(34'(vco), c == 0 ? 34'h0 : c > 10 ? 34'h28 : 34'(4 * c));
		end
		rd(OFF_CTL3, 9'h00f, RESP_OK);
		wr(OFF_CTL3, 9'h001, RESP_OK);
		wr(OFF_STAT, 9'h001, RESP_OK);
		check(34'(fine_period_adjust), 34'h1);
		rd(OFF_STAT, 9'h011, RESP_OK);
		wr(OFF_STAT, 9'h000, RESP_OK);
		check(34'(fine_period_adjust), 34'h0);
		wr(OFF_SRC, 9'h044, RESP_OK);
		wait_mode(M_FBI);
		check(34'({src, bdm, pll_en, fll_en}), 34'hd);
		rd(OFF_STAT, 9'h014, RESP_OK);
		pwr <= 1'b1;
		wr(OFF_SRC, 9'h128, RESP_OK);
		wait_mode(M_FEE);
		check(34'({src, iref, reference_divider, fll_en}), 34'h0b);
		rd(OFF_STAT, 9'h002, RESP_OK);
		wr(OFF_SRC, 9'h004, RESP_OK);
		wait_mode(M_FEI);
		rd(OFF_STAT, 9'h010, RESP_OK);
		drift <= 1'b1;
		repeat (8) @(posedge ref_clk_i);
		#1;
		check(34'(irq), 34'h0);
		rd(OFF_STAT, 9'h090, RESP_OK);
		wr(OFF_CTL3, 9'h081, RESP_OK);
		check(34'(irq), 34'h1);
		wr(OFF_STAT, 9'h000, RESP_OK);
		rd(OFF_STAT, 9'h090, RESP_OK);
		wr(OFF_STAT, 9'h080, RESP_OK);
		rd(OFF_STAT, 9'h010, RESP_OK);
		check(34'(irq), 34'h0);
		wr(OFF_SRC, 9'h005, RESP_OK);
		fail <= 1'b1;
		repeat (8) @(posedge ref_clk_i);
		#1;
		check(34'(rreq), 34'h0);
		wr(OFF_CTL3, 9'h021, RESP_OK);
		@(posedge ref_clk_i);
		#1;
		check(34'(rreq), 34'h1);
		wr(OFF_CTL3, 9'h041, RESP_OK);
		@(posedge ref_clk_i);
		#1;
		check(34'({rreq, pll_en, fll_en}), 34'h0);
		// Loop select already set: external engaged now means the PLL runs
		fail <= 1'b0;
		wr(OFF_SRC, 9'h128, RESP_OK);
		wait_mode(M_PEE);
		check(34'({src, pll_en, fll_en}), 34'he);
		rd(OFF_STAT, 9'h02e, RESP_OK);
		give_verdict();
	end
endmodule // fll_pll_clock_mode_control_bench

// ### fpc_clock_ctrl.sv
// Clock mode control: registers over AXI4-Lite, mode machine and clock routing
`timescale 1ns/1ns
// Notes on behaviour
// - Set oscillator flag after startup when external used
// - Clear flag on select clear or internal idle
// - Fine trim bit nudges internal reference period
// - Unlock interrupt when enable and sticky flag
// - Sticky unlock flag, write one clears
// - Loop select picks FLL or PLL
// - Clock monitor requests reset on clock loss
// - VCO code gives four times multiplier
// - Code zero reserved, high codes give forty
// - FLL engaged internal is default mode
// - Internal engaged mode: output from FLL
// - FLL locks to 1024 times divided reference
// - FLL modes: debug clock from FLL, PLL off
// - FLL engaged external entry conditions
// - External engaged mode: FLL from external reference
// - FLL bypassed internal entry conditions
// - Bypassed internal: output from internal reference
// - Source status reports selected clock after sync
module fpc_clock_ctrl (
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire fpc_pkg::fpc_axi_req_s axi_req_i,
	output fpc_pkg::fpc_axi_rsp_s axi_rsp_o,
	input wire logic osc_ready_i,
	input wire logic lock_lost_i,
	input wire logic ext_clk_lost_i,
	input wire logic stop_i,
	output logic irq_o,
	output logic reset_req_o,
	output logic fll_enable_o,
	output logic pll_enable_o,
	output logic [1:0] out_src_o,
	output logic bdm_from_fll_o,
	output logic int_ref_o,
	output logic [2:0] ref_div_o,
	output logic fine_period_adjust_o,
	output logic [5:0] vco_factor_o,
	output logic [8:0] mode_o
);
	import fpc_pkg::*;

	typedef struct packed {
		fpc_axi_rsp_s rsp;
		logic aw_held;
		logic [ADDR_W-1:0] awaddr;
		logic w_held;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [2:0] s1;
		logic [2:0] s2;
		logic [2:0] s3;
		logic [2:0] filt;
		logic fine_period_adjust;
		logic ulk;
		logic osc;
		logic [7:0] ctl3;
		logic [8:0] src;
		fpc_mode_e mode;
		logic [2:0] sw_cnt;
		logic [1:0] cst;
		logic fll_en;
		logic pll_en;
		logic bdm_fll;
		logic irq;
		logic rst_req;
		logic [5:0] vco;
	} fpc_state_s;

	fpc_state_s st_reg;
	fpc_state_s st_next;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic ext_mode(input fpc_mode_e m);
		ext_mode = m inside {M_FEE, M_FBE, M_PEE, M_PBE, M_LOW_POWER_EXT_BYPASS};
	endfunction

	function automatic logic int_mode(input fpc_mode_e m);
		int_mode = m inside {M_FEI, M_FBI, M_LOW_POWER_INT_BYPASS};
	endfunction

	function automatic logic [5:0] vco_factor(input logic [3:0] code);
		if (code == 4'h0)
			vco_factor = 6'h00;
		else if (code > VCO_LAST)
			vco_factor = VCO_MAX;
		else
			vco_factor = {code, 2'b00};
	endfunction

	// Illegal field combinations keep the current mode
	function automatic fpc_mode_e decode(input logic [1:0] clock_source_select, input logic internal_ref_select, input logic pll,
		input logic lp, input fpc_mode_e cur);
		decode = cur;
		case (clock_source_select)
			CS_FLL:
			begin
				if (internal_ref_select && !pll)
					decode = M_FEI;
				else if (!internal_ref_select)
					decode = pll ? M_PEE : M_FEE;
			end
			CS_INT:
			begin
				if (internal_ref_select && lp)
					decode = M_LOW_POWER_INT_BYPASS;
				else if (internal_ref_select && !pll)
					decode = M_FBI;
			end
			CS_EXT:
			begin
				if (!internal_ref_select && lp)
					decode = M_LOW_POWER_EXT_BYPASS;
				else if (!internal_ref_select)
					decode = pll ? M_PBE : M_FBE;
			end
			default:
				decode = cur;
		endcase
	endfunction

	function automatic logic [1:0] src_of(input fpc_mode_e m, input logic [1:0] prev);
		case (m)
			M_FEI, M_FEE: src_of = CS_FLL;
			M_FBI, M_LOW_POWER_INT_BYPASS: src_of = CS_INT;
			M_FBE, M_PBE, M_LOW_POWER_EXT_BYPASS: src_of = CS_EXT;
			M_PEE: src_of = CS_PLL;
			default: src_of = prev;
		endcase
	endfunction

	function automatic logic [31:0] rd_word(input fpc_state_s s, input logic [ADDR_W-1:0] a);
		rd_word = 32'h0;
		case (a)
			OFF_STAT:
			begin
				rd_word[B_ULK] = s.ulk;
				rd_word[B_PST] = s.mode inside {M_PEE, M_PBE};
				rd_word[B_RST] = int_mode(s.mode);
				rd_word[B_CST+:2] = s.cst;
				rd_word[B_OSC] = s.osc;
				rd_word[B_FTR] = s.fine_period_adjust;
			end
			OFF_CTL3: rd_word[7:0] = s.ctl3;
			OFF_SRC: rd_word[8:0] = s.src;
			OFF_MODE: rd_word[8:0] = s.mode;
			default: rd_word = 32'h0;
		endcase
	endfunction

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = a inside {OFF_STAT, OFF_CTL3, OFF_SRC, OFF_MODE};
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		fpc_mode_e tgt;
		logic ext_ok;
		logic lol_rise;
		tgt = M_FEI;
		ext_ok = 1'b0;
		lol_rise = 1'b0;
		st_next = st_reg;

		// Pin inputs: a change counts once stages two and three agree
		st_next.s1 = {ext_clk_lost_i, lock_lost_i, osc_ready_i};
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		for (int i = 0; i < 3; i++)
			if (st_reg.s2[i] == st_reg.s3[i])
				st_next.filt[i] = st_reg.s3[i];
		lol_rise = st_next.filt[P_LOL] && !st_reg.filt[P_LOL];

		// Write channel: address and data taken in either order
		if (axi_req_i.awvalid && st_reg.rsp.awready)
		begin
			st_next.aw_held = 1'b1;
			st_next.awaddr = axi_req_i.awaddr;
		end
		if (axi_req_i.wvalid && st_reg.rsp.wready)
		begin
			st_next.w_held = 1'b1;
			st_next.wdata = axi_req_i.wdata;
			st_next.wstrb = axi_req_i.wstrb;
		end
		if (st_reg.rsp.bvalid && axi_req_i.bready)
			st_next.rsp.bvalid = 1'b0;
		if (st_next.aw_held && st_next.w_held && !st_reg.rsp.bvalid)
		begin
			st_next.aw_held = 1'b0;
			st_next.w_held = 1'b0;
			st_next.rsp.bvalid = 1'b1;
			st_next.rsp.bresp = mapped(st_next.awaddr) ? RESP_OK : RESP_ERR;
			if (st_next.wstrb[0])
			begin
				case (st_next.awaddr)
					OFF_STAT:
					begin
						st_next.fine_period_adjust = st_next.wdata[B_FTR];
						if (st_next.wdata[B_ULK])
							st_next.ulk = 1'b0;
					end
					OFF_CTL3: st_next.ctl3 = st_next.wdata[7:0] & CTL3_WMASK;
					OFF_SRC: st_next.src[7:0] = st_next.wdata[7:0];
					default: st_next.src = st_next.src;
				endcase
			end
			if (st_next.wstrb[1] && st_next.awaddr == OFF_SRC)
				st_next.src[B_EXT_OSC_SELECT] = st_next.wdata[B_EXT_OSC_SELECT];
		end
		st_next.rsp.awready = !st_next.aw_held && !st_next.rsp.bvalid;
		st_next.rsp.wready = !st_next.w_held && !st_next.rsp.bvalid;

		// Read channel: data one cycle after the address is taken
		if (st_reg.rsp.rvalid && axi_req_i.rready)
			st_next.rsp.rvalid = 1'b0;
		if (axi_req_i.arvalid && st_reg.rsp.arready)
		begin
			st_next.rsp.rvalid = 1'b1;
			st_next.rsp.rdata = rd_word(st_reg, axi_req_i.araddr);
			st_next.rsp.rresp = mapped(axi_req_i.araddr) ? RESP_OK : RESP_ERR;
		end
		st_next.rsp.arready = !st_next.rsp.rvalid;

		// Loss of lock: hardware set wins over a same-cycle clear
		if (lol_rise && (st_reg.fll_en || st_reg.pll_en))
			st_next.ulk = 1'b1;

		// Mode machine; a switch waits for sync and an available clock
		tgt = decode(st_next.src[B_CLOCK_SOURCE_SELECT+:2], st_next.src[B_INTERNAL_REF_SELECT], st_next.ctl3[B_LS],
			st_next.src[B_LP], st_reg.mode);
		ext_ok = (!st_next.src[B_EXT_OSC_SELECT] || st_reg.osc) && !st_reg.filt[P_XLOST];
		if (stop_i)
		begin
			st_next.mode = M_STOP;
			st_next.sw_cnt = 3'h0;
		end
		else if (tgt == st_reg.mode || (ext_mode(tgt) && !ext_ok))
			st_next.sw_cnt = 3'h0;
		else if (st_reg.sw_cnt == SWITCH_CYC - 3'h1)
		begin
			st_next.mode = tgt;
			st_next.sw_cnt = 3'h0;
		end
		else
			st_next.sw_cnt = st_reg.sw_cnt + 3'h1;

		st_next.cst = src_of(st_next.mode, st_reg.cst);
		st_next.fll_en = !st_next.ctl3[B_LS] &&
			(st_next.mode inside {M_FEI, M_FEE, M_FBI, M_FBE});
		st_next.pll_en = st_next.ctl3[B_LS] && (st_next.mode inside {M_PEE, M_PBE});
		st_next.bdm_fll = st_next.mode inside {M_FEI, M_FEE, M_FBI, M_FBE};

		// Oscillator started flag
		// A pending switch to an external mode needs the oscillator too;
		// without this the switch would wait on a flag that never sets
		if (st_next.src[B_EXT_OSC_SELECT] && st_reg.filt[P_OSC] &&
			(st_next.src[B_ERCLK] || ext_mode(st_next.mode) || ext_mode(tgt)))
			st_next.osc = 1'b1;
		else if (!st_next.src[B_EXT_OSC_SELECT] || (int_mode(st_next.mode) && !st_next.src[B_ERCLK]))
			st_next.osc = 1'b0;

		st_next.irq = st_next.ctl3[B_IE] && st_next.ulk;
		st_next.rst_req = st_next.ctl3[B_CME] && st_next.filt[P_XLOST];
		st_next.vco = vco_factor(st_next.ctl3[B_VCO+:4]);

		if (srst_i)
		begin
			st_next = '0;
			st_next.mode = M_FEI;
			st_next.ctl3 = RST_CTL3;
			st_next.src = RST_SRC;
			st_next.fine_period_adjust = RST_FINE_PERIOD_ADJUST;
			st_next.cst = CS_FLL;
			st_next.bdm_fll = 1'b1;
			st_next.vco = vco_factor(RST_CTL3[B_VCO+:4]);
		end
	end

	always_ff @(posedge ref_clk_i)
		st_reg <= st_next;

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign axi_rsp_o = st_reg.rsp;
	assign irq_o = st_reg.irq;
	assign reset_req_o = st_reg.rst_req;
	assign fll_enable_o = st_reg.fll_en;
	assign pll_enable_o = st_reg.pll_en;
	assign out_src_o = st_reg.cst;
	assign bdm_from_fll_o = st_reg.bdm_fll;
	assign int_ref_o = st_reg.src[B_INTERNAL_REF_SELECT];
	assign ref_div_o = st_reg.src[B_REFERENCE_DIVIDER+:3];
	assign fine_period_adjust_o = st_reg.fine_period_adjust;
	assign vco_factor_o = st_reg.vco;
	assign mode_o = st_reg.mode;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (srst_i);

	irq_cause_a: assert property (irq_o |-> st_reg.ulk && st_reg.ctl3[B_IE])
		else $error("interrupt without enable and sticky flag");
	ulk_set_a: assert property ($rose(st_reg.ulk) |-> $past(st_reg.fll_en || st_reg.pll_en))
		else $error("unlock flag set with lock detection off");
	loop_excl_a: assert property ((fll_enable_o |-> !st_reg.ctl3[B_LS]) and
		(pll_enable_o |-> st_reg.ctl3[B_LS]))
		else $error("disabled loop is running");
	cme_gate_a: assert property (reset_req_o |-> st_reg.ctl3[B_CME])
		else $error("reset request with monitor off");
	vco_high_a: assert property (st_reg.ctl3[3:0] > 4'ha |-> vco_factor_o == 6'h28)
		else $error("reserved code not forty");
	fei_route_a: assert property (mode_o == M_FEI |-> out_src_o == CS_FLL && bdm_from_fll_o
		&& !pll_enable_o)
		else $error("internal engaged routing wrong");
	// Loop select set while bypassed keeps the mode but must still stop the FLL
	fbi_route_a: assert property (mode_o == M_FBI |-> out_src_o == CS_INT && fll_enable_o == !st_reg.ctl3[B_LS])
		else $error("bypassed internal routing wrong");
	// The reference select may already point inward while a switch out of FEE is pending
	fee_route_a: assert property ((mode_o == M_FEE |-> out_src_o == CS_FLL) and
		($rose(mode_o == M_FEE) |-> !int_ref_o))
		else $error("external engaged routing wrong");
	osc_set_a: assert property ($rose(st_reg.osc) |-> st_reg.src[B_EXT_OSC_SELECT])
		else $error("oscillator flag set without select");
	osc_clr_a: assert property ($fell(st_reg.osc) |-> !st_reg.src[B_EXT_OSC_SELECT] ||
		(int_mode(st_reg.mode) && !st_reg.src[B_ERCLK]))
		else $error("oscillator flag cleared without cause");
	sw_wait_a: assert property ($changed(st_reg.mode) && !stop_i && !$past(stop_i) |->
		$past(st_reg.sw_cnt) == 3'h3)
		else $error("mode switched before sync");

	fee_cov_c: cover property (mode_o == M_FEE);
	pee_cov_c: cover property (mode_o == M_PEE);
	irq_cov_c: cover property ($rose(irq_o));
	wr_cov_c: cover property (axi_rsp_o.bvalid && axi_req_i.bready);

endmodule // fpc_clock_ctrl

// ### fpc_osc_model.sv
// External oscillator partner: start-up count, lock drift and clock loss
`timescale 1ns/1ns
module fpc_osc_model #(parameter int STARTUP_CYC = 20) (
	input wire logic ref_clk_i,
	input wire logic power_i,
	input wire logic drift_i,
	input wire logic fail_i,
	output logic osc_ready_o = 1'b0,
	output logic lock_lost_o,
	output logic ext_clk_lost_o
);
	int cnt = 0;
	// Powering down restarts the start-up count, as a real crystal would
	always @(posedge ref_clk_i)
	begin
		cnt <= power_i ? (cnt < STARTUP_CYC ? cnt + 1 : cnt) : 0;
		osc_ready_o <= power_i && (cnt == STARTUP_CYC);
	end
	assign lock_lost_o = drift_i;
	// An unpowered oscillator gives no clock at all
	assign ext_clk_lost_o = fail_i || !power_i;
endmodule // fpc_osc_model

// ### fpc_pkg.sv
// Package: register map, field layout, modes and bus carriers of the clock mode control
package fpc_pkg;

	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_STAT = 8'h00;
	localparam logic [7:0] OFF_CTL3 = 8'h04;
	localparam logic [7:0] OFF_SRC = 8'h08;
	localparam logic [7:0] OFF_MODE = 8'h0c;

	// Status and trim register fields
	localparam int B_ULK = 7;
	localparam int B_PST = 5;
	localparam int B_RST = 4;
	localparam int B_CST = 2;
	localparam int B_OSC = 1;
	localparam int B_FTR = 0;
	// Control three fields
	localparam int B_IE = 7;
	localparam int B_LS = 6;
	localparam int B_CME = 5;
	localparam int B_VCO = 0;
	localparam logic [7:0] CTL3_WMASK = 8'hef;
	// Source control fields
	localparam int B_CLOCK_SOURCE_SELECT = 6;
	localparam int B_REFERENCE_DIVIDER = 3;
	localparam int B_INTERNAL_REF_SELECT = 2;
	localparam int B_LP = 1;
	localparam int B_ERCLK = 0;
	localparam int B_EXT_OSC_SELECT = 8;

	localparam logic [7:0] RST_CTL3 = 8'h01;
	localparam logic [8:0] RST_SRC = 9'h004;
	localparam logic RST_FINE_PERIOD_ADJUST = 1'b0;
	localparam logic [2:0] SWITCH_CYC = 3'h4;
	localparam logic [3:0] VCO_LAST = 4'ha;
	localparam logic [5:0] VCO_MAX = 6'h28;

	// Pin inputs index
	localparam int P_OSC = 0;
	localparam int P_LOL = 1;
	localparam int P_XLOST = 2;

	localparam logic [1:0] CS_FLL = 2'h0;
	localparam logic [1:0] CS_INT = 2'h1;
	localparam logic [1:0] CS_EXT = 2'h2;
	localparam logic [1:0] CS_PLL = 2'h3;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	typedef enum logic [8:0] {
		M_FEI = 9'h001, M_FEE = 9'h002, M_FBI = 9'h004, M_FBE = 9'h008, M_PEE = 9'h010,
		M_PBE = 9'h020, M_LOW_POWER_INT_BYPASS = 9'h040, M_LOW_POWER_EXT_BYPASS = 9'h080, M_STOP = 9'h100
	} fpc_mode_e;

	typedef struct packed {
		logic [ADDR_W-1:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [ADDR_W-1:0] araddr;
		logic arvalid;
		logic rready;
	} fpc_axi_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} fpc_axi_rsp_s;

endpackage
